/* File: nand_host_ctrl.sv */
// host-side sequencer driving a parallel nand flash through its pins
//
// Overview of operation
// - x8 sends five address bytes, set layout
// - x16 five address bytes, upper byte low
// - unused address bits driven low
// - page read 00h, address, 30h/35h
// - program 80h, address, data, 10h/15h
// - 85h random input, then 10h copy-back
// - erase 60h, row address, D0h
// - 90h reads identification bytes
// - random output 05h, column, E0h
// - cache read 00h..31h, exit 34h
// - command needs ce low, cle high, ale low
// - command codes on low io byte
`timescale 1ns/1ps
`default_nettype none

module nand_host_ctrl
   import nand_host_pkg::*;
#(
   parameter int IO_W = 8,
   parameter int LEN_W = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reqValid,
   input wire logic [3:0] reqOp,
   input wire logic [ADDR_W-1:0] reqAddr,
   input wire logic [LEN_W-1:0] reqLen,
   input wire logic writeProtect,
   output logic reqReady,
   output logic reqDone,
   output logic reqRefused,
   input wire logic [IO_W-1:0] wrData,
   input wire logic wrValid,
   output logic wrReady,
   output logic [IO_W-1:0] rdData,
   output logic rdValid,
   output logic ceN,
   output logic cmdLatch,
   output logic addrLatch,
   output logic wrStrobeN,
   output logic rdStrobeN,
   output logic wpN,
   output logic [IO_W-1:0] ioOut,
   output logic ioOe,
   input wire logic [IO_W-1:0] ioIn,
   input wire logic readyIn
);

   // ---------------------------------------------------------------
   // operation table
   // ---------------------------------------------------------------
   function automatic opdesc_s mkDesc(input logic [7:0] first, input logic [7:0] conf,
                                      input logic hc, input logic [2:0] af,
                                      input logic [2:0] al, input logic ha,
                                      input logic [6:0] fl);
      opdesc_s d;
      d.first = first;
      d.conf = conf;
      d.hasConf = hc;
      d.aFirst = af;
      d.aLast = al;
      d.hasAddr = ha;
      {d.hasWr, d.hasWait, d.hasRd, d.modify, d.busyOk, d.x8Only, d.legal} = fl;
      return d;
   endfunction

   // flags: wr, wait, rd, modify, busyOk, x8Only, legal
   function automatic opdesc_s opDesc(input op_e op);
      opdesc_s d;
      d = mkDesc(CODE_NONE, CODE_NONE, 1'b0, ADDR_IDX_FIRST, ADDR_IDX_FIRST, 1'b0, 7'h00);
      case (op)
         OP_READ: d = mkDesc(CMD_READ_SETUP, CMD_READ_CONF, 1'b1, ADDR_IDX_FIRST,
                             ADDR_IDX_LAST, 1'b1, 7'b0110001);
         OP_READ_CB: d = mkDesc(CMD_READ_SETUP, CMD_READ_CB_CONF, 1'b1, ADDR_IDX_FIRST,
                                ADDR_IDX_LAST, 1'b1, 7'b0110001);
         OP_CACHE_RD: d = mkDesc(CMD_READ_SETUP, CMD_CACHE_RD_CONF, 1'b1, ADDR_IDX_FIRST,
                                 ADDR_IDX_LAST, 1'b1, 7'b0110011);
         OP_CACHE_EXIT: d = mkDesc(CMD_CACHE_RD_EXIT, CODE_NONE, 1'b0, ADDR_IDX_FIRST,
                                   ADDR_IDX_FIRST, 1'b0, 7'b0110011);
         OP_RAND_OUT: d = mkDesc(CMD_RAND_OUT, CMD_RAND_OUT_CONF, 1'b1, ADDR_IDX_FIRST,
                                 ADDR_IDX_COL_LAST, 1'b1, 7'b0010001);
         OP_READ_ID: d = mkDesc(CMD_READ_ID, CODE_NONE, 1'b0, ADDR_IDX_FIRST,
                                ADDR_IDX_FIRST, 1'b1, 7'b0010001);
         OP_STATUS: d = mkDesc(CMD_STATUS, CODE_NONE, 1'b0, ADDR_IDX_FIRST,
                               ADDR_IDX_FIRST, 1'b0, 7'b0010101);
         OP_RESET: d = mkDesc(CMD_RESET, CODE_NONE, 1'b0, ADDR_IDX_FIRST,
                              ADDR_IDX_FIRST, 1'b0, 7'b0100101);
         OP_PROG: d = mkDesc(CMD_PROG_SETUP, CMD_PROG_CONF, 1'b1, ADDR_IDX_FIRST,
                             ADDR_IDX_LAST, 1'b1, 7'b1101001);
         OP_CACHE_PROG: d = mkDesc(CMD_PROG_SETUP, CMD_CACHE_PROG_CONF, 1'b1, ADDR_IDX_FIRST,
                                   ADDR_IDX_LAST, 1'b1, 7'b1101001);
         OP_COPY_PROG: d = mkDesc(CMD_RAND_IN, CMD_PROG_CONF, 1'b1, ADDR_IDX_FIRST,
                                  ADDR_IDX_LAST, 1'b1, 7'b1101001);
         OP_RAND_IN: d = mkDesc(CMD_RAND_IN, CODE_NONE, 1'b0, ADDR_IDX_FIRST,
                                ADDR_IDX_COL_LAST, 1'b1, 7'b1000001);
         OP_ERASE: d = mkDesc(CMD_ERASE_SETUP, CMD_ERASE_CONF, 1'b1, ADDR_IDX_ROW,
                              ADDR_IDX_LAST, 1'b1, 7'b0101001);
         default: d.legal = 1'b0;
      endcase
      return d;
   endfunction

   function automatic logic [7:0] addrByte(input logic [ADDR_W-1:0] a, input logic [2:0] i);
      logic wide;
      logic [7:0] b;
      wide = (IO_W == X16_IO_W);
      case (i)
         3'h0: b = fieldByte(a, ADDR_B0_LSB, BYTE_W);
         3'h1: b = wide ? fieldByte(a, X16_B1_LSB, X16_B1_W) : fieldByte(a, X8_B1_LSB, X8_B1_W);
         3'h2: b = wide ? fieldByte(a, X16_B2_LSB, BYTE_W) : fieldByte(a, X8_B2_LSB, BYTE_W);
         3'h3: b = wide ? fieldByte(a, X16_B3_LSB, BYTE_W) : fieldByte(a, X8_B3_LSB, BYTE_W);
         3'h4: b = wide ? fieldByte(a, X16_B4_LSB, LAST_CYC_W)
                        : fieldByte(a, X8_B4_LSB, LAST_CYC_W);
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   function automatic state_e nextStage(input opdesc_s d, input state_e st,
                                        input logic noData);
      state_e s;
      s = S_DONE;
      if (st == S_CMD1 && d.hasAddr) begin
         s = S_ADDR;
      end else if (st inside {S_CMD1, S_ADDR} && d.hasWr && !noData) begin
         s = S_DATA;
      end else if (st inside {S_CMD1, S_ADDR, S_DATA} && d.hasConf) begin
         s = S_CONF;
      end else if (st inside {S_CMD1, S_ADDR, S_DATA, S_CONF} && d.hasWait) begin
         s = S_WAIT;
      end else if (st != S_RDAT && d.hasRd && !noData) begin
         s = S_RDAT;
      end
      return s;
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [IO_W-1:0] ioSync;
   logic rbSync;

   pin_sync #(.W(IO_W + 1)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({readyIn, ioIn}),
      .q({rbSync, ioSync})
   );

   // ---------------------------------------------------------------
   // sequencer state
   // ---------------------------------------------------------------
   state_e state_q, state_d, nxt;
   op_e op_q, op_d, opIn;
   opdesc_s dq, dIn;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [LEN_W-1:0] rem_q, rem_d;
   logic [2:0] idx_q, idx_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic low_q, low_d, act_q, act_d;
   logic ceN_q, ceN_d, cle_q, cle_d, ale_q, ale_d, weN_q, weN_d, reN_q, reN_d;
   logic oe_q, oe_d, wpN_q;
   logic [IO_W-1:0] io_q, io_d, wval, rdData_q, rdData_d;
   logic rdy_q, rdy_d, done_q, done_d, ref_q, ref_d, wrRdy_q, wrRdy_d;
   logic rdVal_q, rdVal_d;
   logic go, launchW, launchR, cycEnd;

   assign opIn = op_e'(reqOp);
   assign dIn = opDesc(opIn);
   assign dq = opDesc(op_q);

   always_comb begin
      state_d = state_q;
      op_d = op_q;
      addr_d = addr_q;
      rem_d = rem_q;
      idx_d = idx_q;
      cnt_d = cnt_q;
      low_d = low_q;
      act_d = act_q;
      ceN_d = ceN_q;
      cle_d = cle_q;
      ale_d = ale_q;
      weN_d = weN_q;
      reN_d = reN_q;
      oe_d = oe_q;
      io_d = io_q;
      rdy_d = rdy_q;
      done_d = 1'b0;
      ref_d = 1'b0;
      wrRdy_d = wrRdy_q;
      rdData_d = rdData_q;
      rdVal_d = 1'b0;
      nxt = state_q;
      go = 1'b0;
      launchW = 1'b0;
      launchR = 1'b0;
      wval = '0;
      cycEnd = act_q && !low_q && (cnt_q == '0);

      // strobe low phase, then high phase, per bus cycle
      if (act_q) begin
         if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
         end else if (low_q) begin
            low_d = 1'b0;
            weN_d = 1'b1;
            reN_d = 1'b1;
            cnt_d = (state_q == S_RDAT) ? CNT_W'(RD_HIGH_CYC - 1) : CNT_W'(WE_HIGH_CYC - 1);
            if (state_q == S_RDAT) begin
               rdData_d = ioSync;
               rdVal_d = 1'b1;
            end
         end else begin
            act_d = 1'b0;
         end
      end

      case (state_q)
         S_IDLE: begin
            ceN_d = 1'b1;
            if (reqValid && rdy_q) begin
               // only reset and status while busy
               if (!dIn.legal || (!rbSync && !dIn.busyOk) || (dIn.modify && writeProtect) ||
                   (dIn.x8Only && IO_W == X16_IO_W)) begin
                  ref_d = 1'b1;
               end else begin
                  rdy_d = 1'b0;
                  op_d = opIn;
                  addr_d = reqAddr;
                  rem_d = reqLen;
                  ceN_d = 1'b0;
                  state_d = S_CMD1;
                  cle_d = 1'b1;
                  ale_d = 1'b0;
                  launchW = 1'b1;
                  wval = IO_W'(dIn.first);
               end
            end
         end
         S_CMD1, S_ADDR, S_CONF: begin
            if (cycEnd) begin
               if (state_q == S_ADDR && idx_q != dq.aLast) begin
                  idx_d = idx_q + 1'b1;
                  launchW = 1'b1;
                  wval = IO_W'(addrByte(addr_q, idx_q + 1'b1));
               end else begin
                  go = 1'b1;
               end
            end
         end
         S_DATA: begin
            if (cycEnd) begin
               rem_d = rem_q - 1'b1;
               if (rem_q == LEN_W'(1)) begin
                  go = 1'b1;
               end else begin
                  wrRdy_d = 1'b1;
               end
            end else if (wrRdy_q && wrValid && !act_q) begin
               wrRdy_d = 1'b0;
               launchW = 1'b1;
               wval = wrData;
            end
         end
         S_WAIT: begin
            if (low_q) begin
               if (cnt_q != '0) begin
                  cnt_d = cnt_q - 1'b1;
               end else begin
                  low_d = 1'b0;
               end
            end else if (rbSync) begin
               go = 1'b1;
            end
         end
         S_RDAT: begin
            if (cycEnd) begin
               rem_d = rem_q - 1'b1;
               if (rem_q == LEN_W'(1)) begin
                  go = 1'b1;
               end else begin
                  launchR = 1'b1;
               end
            end
         end
         S_DONE: begin
            done_d = 1'b1;
            rdy_d = 1'b1;
            ceN_d = 1'b1;
            state_d = S_IDLE;
         end
         default: state_d = S_IDLE;
      endcase

      if (go) begin
         nxt = nextStage(dq, state_q, rem_q == '0);
         state_d = nxt;
         cle_d = 1'b0;
         ale_d = 1'b0;
         oe_d = 1'b0;
         case (nxt)
            S_ADDR: begin
               ale_d = 1'b1;
               idx_d = dq.aFirst;
               launchW = 1'b1;
               wval = IO_W'(addrByte(addr_q, dq.aFirst));
            end
            S_DATA: wrRdy_d = 1'b1;
            S_CONF: begin
               cle_d = 1'b1;
               launchW = 1'b1;
               wval = IO_W'(dq.conf);
            end
            S_WAIT: begin
               low_d = 1'b1;
               cnt_d = CNT_W'(WB_CYC - 1);
            end
            S_RDAT: launchR = 1'b1;
            default: ;
         endcase
      end

      // io held through write strobe rise
      if (launchW) begin
         weN_d = 1'b0;
         oe_d = 1'b1;
         io_d = wval;
         act_d = 1'b1;
         low_d = 1'b1;
         cnt_d = CNT_W'(WE_LOW_CYC - 1);
      end
      if (launchR) begin
         oe_d = 1'b0;
         reN_d = 1'b0;
         act_d = 1'b1;
         low_d = 1'b1;
         cnt_d = CNT_W'(RD_LOW_CYC - 1);
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= S_IDLE;
         op_q <= OP_READ;
         addr_q <= '0;
         rem_q <= '0;
         idx_q <= ADDR_IDX_FIRST;
         cnt_q <= '0;
         low_q <= 1'b0;
         act_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         addr_q <= addr_d;
         rem_q <= rem_d;
         idx_q <= idx_d;
         cnt_q <= cnt_d;
         low_q <= low_d;
         act_q <= act_d;
      end
   end

   // chip select held low until done
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ceN_q <= 1'b1;
         cle_q <= 1'b0;
         ale_q <= 1'b0;
         weN_q <= 1'b1;
         reN_q <= 1'b1;
         oe_q <= 1'b0;
         io_q <= '0;
         wpN_q <= 1'b0;
      end else begin
         ceN_q <= ceN_d;
         cle_q <= cle_d;
         ale_q <= ale_d;
         weN_q <= weN_d;
         reN_q <= reN_d;
         oe_q <= oe_d;
         io_q <= io_d;
         wpN_q <= !writeProtect;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdy_q <= 1'b1;
         done_q <= 1'b0;
         ref_q <= 1'b0;
         wrRdy_q <= 1'b0;
         rdData_q <= '0;
         rdVal_q <= 1'b0;
      end else begin
         rdy_q <= rdy_d;
         done_q <= done_d;
         ref_q <= ref_d;
         wrRdy_q <= wrRdy_d;
         rdData_q <= rdData_d;
         rdVal_q <= rdVal_d;
      end
   end

   assign reqReady = rdy_q;
   assign reqDone = done_q;
   assign reqRefused = ref_q;
   assign wrReady = wrRdy_q;
   assign rdData = rdData_q;
   assign rdValid = rdVal_q;
   assign ceN = ceN_q;
   assign cmdLatch = cle_q;
   assign addrLatch = ale_q;
   assign wrStrobeN = weN_q;
   assign rdStrobeN = reN_q;
   assign wpN = wpN_q;
   assign ioOut = io_q;
   assign ioOe = oe_q;

endmodule

`default_nettype wire

/* File: nand_host_pkg.sv */
// shared constants, codes and types for the nand host controller
package nand_host_pkg;

   // ---------------------------------------------------------------
   // clock and strobe timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_WE_LOW_NS = 24;
   localparam int T_WE_HIGH_NS = 16;
   localparam int T_RD_HIGH_NS = 16;
   // rd_access_delay: data valid after read strobe falls
   localparam int T_RD_ACCESS_NS = 20;
   localparam int T_WB_NS = 100;
   localparam int SYNC_STAGES = 2;

   // least times: round up, never below one cycle
   function automatic int nsToCyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int WE_LOW_CYC = nsToCyc(T_WE_LOW_NS);
   localparam int WE_HIGH_CYC = nsToCyc(T_WE_HIGH_NS);
   localparam int RD_HIGH_CYC = nsToCyc(T_RD_HIGH_NS);
   // sampling waits for the synchroniser too
   localparam int RD_LOW_CYC = nsToCyc(T_RD_ACCESS_NS) + SYNC_STAGES;
   localparam int WB_CYC = nsToCyc(T_WB_NS);
   localparam int CNT_W = 8;

   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_READ_SETUP = 8'h00;
   localparam logic [7:0] CMD_READ_CONF = 8'h30;
   localparam logic [7:0] CMD_READ_CB_CONF = 8'h35;
   localparam logic [7:0] CMD_CACHE_RD_CONF = 8'h31;
   localparam logic [7:0] CMD_CACHE_RD_EXIT = 8'h34;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
   localparam logic [7:0] CMD_PROG_CONF = 8'h10;
   localparam logic [7:0] CMD_CACHE_PROG_CONF = 8'h15;
   localparam logic [7:0] CMD_RAND_IN = 8'h85;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
   localparam logic [7:0] CMD_RAND_OUT = 8'h05;
   localparam logic [7:0] CMD_RAND_OUT_CONF = 8'he0;
   localparam logic [7:0] CODE_NONE = 8'h00;

   // ---------------------------------------------------------------
   // address cycle layout
   // ---------------------------------------------------------------
   localparam int ADDR_W = 29;
   localparam int BYTE_W = 8;
   localparam logic [2:0] ADDR_IDX_FIRST = 3'h0;
   localparam logic [2:0] ADDR_IDX_COL_LAST = 3'h1;
   localparam logic [2:0] ADDR_IDX_ROW = 3'h2;
   localparam logic [2:0] ADDR_IDX_LAST = 3'h4;
   localparam int ADDR_B0_LSB = 0;
   localparam int X8_B1_LSB = 8;
   localparam int X8_B1_W = 4;
   localparam int X8_B2_LSB = 12;
   localparam int X8_B3_LSB = 20;
   localparam int X8_B4_LSB = 28;
   localparam int X16_B1_LSB = 8;
   localparam int X16_B1_W = 3;
   localparam int X16_B2_LSB = 11;
   localparam int X16_B3_LSB = 19;
   localparam int X16_B4_LSB = 27;
   localparam int LAST_CYC_W = 1;
   localparam int X16_IO_W = 16;

   // unused bit positions come out low
   function automatic logic [7:0] fieldByte(input logic [ADDR_W-1:0] a,
                                            input int lsb, input int w);
      logic [ADDR_W-1:0] s;
      s = (a >> lsb) & ((ADDR_W'(1) << w) - ADDR_W'(1));
      return s[BYTE_W-1:0];
   endfunction

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_CMD1 = 3'h1, S_ADDR = 3'h3, S_DATA = 3'h2,
      S_CONF = 3'h6, S_WAIT = 3'h7, S_RDAT = 3'h5, S_DONE = 3'h4
   } state_e;

   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_READ_CB = 4'h1, OP_CACHE_RD = 4'h2,
      OP_CACHE_EXIT = 4'h3, OP_RAND_OUT = 4'h4, OP_READ_ID = 4'h5,
      OP_STATUS = 4'h6, OP_RESET = 4'h7, OP_PROG = 4'h8,
      OP_CACHE_PROG = 4'h9, OP_COPY_PROG = 4'ha, OP_RAND_IN = 4'hb,
      OP_ERASE = 4'hc
   } op_e;

   typedef struct packed {
      logic [7:0] first;
      logic [7:0] conf;
      logic hasConf;
      logic [2:0] aFirst;
      logic [2:0] aLast;
      logic hasAddr;
      logic hasWr;
      logic hasWait;
      logic hasRd;
      logic modify;
      logic busyOk;
      logic x8Only;
      logic legal;
   } opdesc_s;

endpackage

/* File: pin_sync.sv */
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

`default_nettype wire

/* File: nand_dev_model.sv */
// behavioural flash device seen from the host pins
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
   parameter int BUSY = 30
) (
   input wire logic clk,
   input wire logic ceN,
   input wire logic cmdLatch,
   input wire logic addrLatch,
   input wire logic wrStrobeN,
   input wire logic rdStrobeN,
   input wire logic wpN,
   input wire logic hostOe,
   input wire logic [7:0] hostIo,
   output logic [7:0] bus,
   output logic rbN
);
   logic [7:0] cq[$];
   logic [7:0] aq[$];
   logic [7:0] dq[$];
   logic [7:0] col = 8'h00;
   logic [7:0] dout = 8'h00;
   int busyCnt = 0;
   // never floats: host io while host drives, dout while selected and reading
   // released bus shows the inverse, not the last value
   assign bus = hostOe ? hostIo : ((!ceN && !rdStrobeN) ? dout : ~dout);
   // open drain, pulled up while ready
   assign rbN = (busyCnt == 0);
   always @(posedge wrStrobeN) begin
      if (!ceN && cmdLatch && (busyCnt == 0 || bus == 8'hff || bus == 8'h70)) begin
         cq.push_back(bus);
         if (bus inside {8'h30, 8'h35, 8'h31, 8'h34, 8'hff} ||
             (wpN && bus inside {8'h10, 8'h15, 8'hd0})) busyCnt = BUSY;
      end else if (!ceN && addrLatch) begin
         aq.push_back(bus);
         if (aq.size() == 1) col = bus;
      end else if (!ceN) dq.push_back(bus);
   end
   // next word on read strobe fall
   always @(negedge rdStrobeN) begin
      if (!ceN) begin
         dout = (cq.size() > 0 && cq[$] == 8'h70) ? 8'hc0 : col;
         col = col + 8'h01;
      end
   end
   // busy time runs regardless of chip select
   always @(posedge clk) begin
      if (busyCnt > 0) busyCnt--;
   end
endmodule
`default_nettype wire

/* File: nand_host_ctrl_checker.sv */
// pin-level assertions for the nand host sequencer
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl_checker #(
   parameter int IO_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reqValid,
   input wire logic [3:0] reqOp,
   input wire logic reqReady,
   input wire logic reqRefused,
   input wire logic writeProtect,
   input wire logic rdValid,
   input wire logic ceN,
   input wire logic cmdLatch,
   input wire logic addrLatch,
   input wire logic wrStrobeN,
   input wire logic rdStrobeN,
   input wire logic wpN,
   input wire logic [IO_W-1:0] ioOut,
   input wire logic ioOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_cmd_frame: assert property (
      cmdLatch && !wrStrobeN |-> !addrLatch && rdStrobeN && !ceN) else $error("bad cmd cycle");
   a_addr_frame: assert property (
      addrLatch && !wrStrobeN |-> !cmdLatch && rdStrobeN && !ceN) else $error("bad addr cycle");
   a_we_low_len: assert property (
      $fell(wrStrobeN) |-> !wrStrobeN [*3] ##1 wrStrobeN) else $error("write strobe width");
   a_io_hold_rise: assert property (
      $rose(wrStrobeN) |-> (ioOe && $stable(ioOut)) [*2]) else $error("io moved at strobe");
   a_rd_low_len: assert property (
      $fell(rdStrobeN) |-> !rdStrobeN [*5] ##1 rdStrobeN) else $error("read strobe width");
   a_rd_valid_edge: assert property (
      rdValid |-> $rose(rdStrobeN) && !ceN) else $error("read word off strobe");
   a_rd_float: assert property (
      !rdStrobeN |-> !ioOe) else $error("host drives io while reading");
   a_wp_follow: assert property (
      1'b1 |=> wpN == !$past(writeProtect)) else $error("protect pin lags");
   a_wp_refuse: assert property (
      reqValid && reqReady && writeProtect && reqOp inside {4'h8, 4'h9, 4'ha, 4'hc}
      |=> reqRefused && reqReady) else $error("modify op not refused");
   c_read: cover property ($fell(rdStrobeN));
   c_refuse: cover property (reqRefused);
   c_addr: cover property (addrLatch && $rose(wrStrobeN));
endmodule
bind nand_host_ctrl nand_host_ctrl_checker #(.IO_W(IO_W)) chk_u (
   .clk(clk), .rst(rst), .reqValid(reqValid), .reqOp(reqOp), .reqReady(reqReady),
   .reqRefused(reqRefused), .writeProtect(writeProtect), .rdValid(rdValid), .ceN(ceN),
   .cmdLatch(cmdLatch), .addrLatch(addrLatch), .wrStrobeN(wrStrobeN),
   .rdStrobeN(rdStrobeN), .wpN(wpN), .ioOut(ioOut), .ioOe(ioOe));
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the nand host sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import nand_host_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reqValid = 1'b0;
   logic [3:0] reqOp = 4'h0;
   logic [ADDR_W-1:0] reqAddr = 29'h0;
   logic [11:0] reqLen = 12'h000;
   logic writeProtect = 1'b0;
   logic [7:0] wrData = 8'ha0;
   logic wrValid = 1'b1;
   logic reqReady, reqDone, reqRefused, wrReady, rdValid, ceN, cmdLatch, addrLatch;
   logic wrStrobeN, rdStrobeN, wpN, ioOe, rbN;
   logic [7:0] rdData, ioOut, bus;
   logic [7:0] rq[$];
   logic [15:0] io16;
   logic [15:0] aq16[$];
   logic we16, ale16, rf16;
   int ref16 = 0;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int wcnt = 0;
   initial forever #4 clk = ~clk;
   nand_host_ctrl dut_u (.clk(clk), .rst(rst), .reqValid(reqValid), .reqOp(reqOp),
      .reqAddr(reqAddr), .reqLen(reqLen), .writeProtect(writeProtect), .reqReady(reqReady),
      .reqDone(reqDone), .reqRefused(reqRefused), .wrData(wrData), .wrValid(wrValid),
      .wrReady(wrReady), .rdData(rdData), .rdValid(rdValid), .ceN(ceN), .cmdLatch(cmdLatch),
      .addrLatch(addrLatch), .wrStrobeN(wrStrobeN), .rdStrobeN(rdStrobeN), .wpN(wpN),
      .ioOut(ioOut), .ioOe(ioOe), .ioIn(bus), .readyIn(rbN));
   nand_dev_model dev_m (.clk(clk), .ceN(ceN), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
      .wrStrobeN(wrStrobeN), .rdStrobeN(rdStrobeN), .wpN(wpN), .hostOe(ioOe),
      .hostIo(ioOut), .bus(bus), .rbN(rbN));
   // x16 twin on the same requests; only its address bytes and refusals are judged
   nand_host_ctrl #(.IO_W(16)) dut16_u (.clk(clk), .rst(rst), .reqValid(reqValid),
      .reqOp(reqOp), .reqAddr(reqAddr), .reqLen(reqLen), .writeProtect(writeProtect),
      .reqReady(), .reqDone(), .reqRefused(rf16), .wrData({8'h00, wrData}),
      .wrValid(wrValid), .wrReady(), .rdData(), .rdValid(), .ceN(), .cmdLatch(),
      .addrLatch(ale16), .wrStrobeN(we16), .rdStrobeN(), .wpN(), .ioOut(io16), .ioOe(),
      .ioIn({8'h00, bus}), .readyIn(rbN));
   always @(posedge we16) begin
      if (ale16 === 1'b1) aq16.push_back(io16);
   end
   always @(posedge clk) begin
      cyc++;
      if (rdValid === 1'b1) rq.push_back(rdData);
      if (rf16 === 1'b1) ref16++;
      if (wrValid && wrReady === 1'b1) wcnt++;
      if (cyc == 60000) begin
         bad_count++;
         final_report();
      end
   end
   always @(negedge clk) wrData <= 8'ha0 + 8'(wcnt);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // result: 1 done, 2 refused, 0 hung
   task automatic run(input logic [3:0] op, input logic [28:0] a, input logic [11:0] n,
                      output int res);
      dev_m.cq.delete();
      dev_m.aq.delete();
      dev_m.dq.delete();
      rq.delete();
      aq16.delete();
      @(negedge clk);
      reqOp = op;
      reqAddr = a;
      reqLen = n;
      reqValid = 1'b1;
      @(negedge clk);
      reqValid = 1'b0;
      res = 0;
      for (int i = 0; i < 3000 && res == 0; i++) begin
         if (reqRefused === 1'b1) res = 2;
         else if (reqDone === 1'b1) res = 1;
         else @(negedge clk);
      end
   endtask
   task automatic t_codes();
      logic [7:0] f[13] = '{8'h00, 8'h00, 8'h00, 8'h34, 8'h05, 8'h90, 8'h70, 8'hff, 8'h80,
                            8'h80, 8'h85, 8'h85, 8'h60};
      logic [7:0] c[13] = '{8'h30, 8'h35, 8'h31, 8'h34, 8'he0, 8'h90, 8'h70, 8'hff, 8'h10,
                            8'h15, 8'h10, 8'h85, 8'hd0};
      int r;
      for (int k = 0; k < 13; k++) begin
         run(4'(k), 29'h0, 12'h001, r);
         chk(r, 1);
         chk(dev_m.cq[0], f[k]);
         chk(dev_m.cq[$], c[k]);
      end
      chk(ref16, 2);
   endtask
   task automatic t_read();
      logic [7:0] e[5] = '{8'hf1, 8'h0e, 8'hcd, 8'hab, 8'h01};
      logic [15:0] e16[5] = '{16'h00f1, 16'h0006, 16'h009b, 16'h0057, 16'h0001};
      int r;
      run(4'h0, 29'h1abcdef1, 12'h002, r);
      chk(dev_m.aq.size(), 5);
      for (int k = 0; k < 5; k++) chk(dev_m.aq[k], e[k]);
      chk(rq.size(), 2);
      chk(rq[0], 8'hf1);
      chk(rq[1], 8'hf2);
      chk(aq16.size(), 5);
      for (int k = 0; k < 5; k++) chk(aq16[k], e16[k]);
      run(4'h6, 29'h0, 12'h001, r);
      chk(rq[0], 8'hc0);
      run(4'hc, 29'h1abcdef1, 12'h000, r);
      chk(dev_m.aq.size(), 3);
      chk(dev_m.aq[0], 8'hcd);
      chk(dev_m.aq[2], 8'h01);
   endtask
   task automatic t_prog();
      logic [3:0] m[4] = '{4'h8, 4'h9, 4'ha, 4'hc};
      int r;
      int w0;
      writeProtect = 1'b1;
      for (int k = 0; k < 4; k++) begin
         run(m[k], 29'h0, 12'h001, r);
         chk(r, 2);
         chk(dev_m.cq.size(), 0);
      end
      writeProtect = 1'b0;
      run(4'hd, 29'h0, 12'h001, r);
      chk(r, 2);
      w0 = wcnt;
      run(4'h8, 29'h0000123, 12'h001, r);
      chk(r, 1);
      chk(dev_m.dq.size(), 1);
      chk(dev_m.dq[0], 8'ha0 + 8'(w0));
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_codes();
      t_read();
      t_prog();
      final_report();
   end
endmodule
`default_nettype wire
